// ---- core/sbi_pkg.sv ----
package sbi_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] DELAY_OFF = 8'h04;
    localparam logic [7:0] STATE_OFF = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h10;

    // Control register fields.
    localparam int CTRL_SERVO_ON_BIT = 0;
    localparam int CTRL_FSTOP_CMD_BIT = 1;
    localparam int CTRL_ALARM_CLR_BIT = 2;

    // Event bits shared by the status and mask registers.
    localparam int EV_LOCAL_FSTOP = 0;
    localparam int EV_CTRL_FSTOP = 1;
    localparam int EV_MAIN_OFF = 2;
    localparam int EV_ALARM = 3;
    localparam int EV_LOCK_OFF = 4;
    localparam int EV_W = 5;

    // Reset values.
    localparam logic [15:0] DELAY_RST = 16'h0064;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [EV_W-1:0] MASK_RST = 5'h00;

    // Timing: one millisecond tick at the 10 MHz clock.
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [13:0] MS_LAST = 14'(MS_CYCLES - 1);

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum {
        SQ_OFF,
        SQ_ON,
        SQ_BRAKE_WAIT,
        SQ_STOPPED
    } sbi_state_t;

    // Drive outputs toward the power stage.
    typedef struct packed {
        logic brake_release;
        logic base_on;
        logic dyn_brake;
        logic fault_output;
    } sbi_drive_t;

    // Warnings shown in the state register.
    typedef struct packed {
        logic main_power_off_warning;
        logic controller_forced_stop_warning;
        logic local_forced_stop_warning;
    } sbi_warn_t;

endpackage

// ---- core/sbi_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

module sbi_sequencer #(
    parameter int DELAY_W = 16
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status inputs from the amplifier.
    input wire logic local_forced_stop_input,
    input wire logic alarm_in,
    input wire logic main_power_ok,
    input wire logic control_power_ok,
    input wire logic motor_stopped,
    // Drive outputs and interrupt.
    output logic brake_release,
    output logic base_on,
    output logic dyn_brake,
    output logic fault_output,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_r;
    logic [DELAY_W-1:0] brake_sequence_delay_param;
    logic [sbi_pkg::EV_W-1:0] stat_r;
    logic [sbi_pkg::EV_W-1:0] mask_r;
    logic [sbi_pkg::EV_W-1:0] ev_set;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_have_r;
    logic w_have_r;
    logic wr_go;
    logic [31:0] rd_val;
    logic rd_hit;
    sbi_pkg::sbi_state_t state_r;
    sbi_pkg::sbi_warn_t warn_r;
    sbi_pkg::sbi_drive_t drv_nxt;
    logic [13:0] ms_cnt_r;
    logic ms_tick;
    logic [DELAY_W-1:0] brake_to_shutoff_delay;
    logic alarm_latched_r;
    logic servo_on_cmd;
    logic fstop_cmd;
    logic main_off_prev_r;
    logic lock_prev_r;
    logic stop_req;

    assign servo_on_cmd = ctrl_r[sbi_pkg::CTRL_SERVO_ON_BIT];
    assign fstop_cmd = ctrl_r[sbi_pkg::CTRL_FSTOP_CMD_BIT];
    // Local and controller forced stops, alarm and control power loss take priority over every sequenced stop.
    assign stop_req = local_forced_stop_input | fstop_cmd | alarm_latched_r | ~control_power_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data accepted in either order.
    assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sbi_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r == sbi_pkg::CTRL_OFF || awaddr_r == sbi_pkg::DELAY_OFF ||
                    awaddr_r == sbi_pkg::IRQ_STAT_OFF || awaddr_r == sbi_pkg::IRQ_MASK_OFF)
                    ? sbi_pkg::RESP_OKAY : sbi_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control, delay and mask registers.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= sbi_pkg::CTRL_RST;
            brake_sequence_delay_param <= DELAY_W'(sbi_pkg::DELAY_RST);
            mask_r <= sbi_pkg::MASK_RST;
        end
        else
        begin
            ctrl_r[sbi_pkg::CTRL_ALARM_CLR_BIT] <= 1'b0;
            if (wr_go && wstrb_r[0])
            begin
                if (awaddr_r == sbi_pkg::CTRL_OFF)
                begin
                    ctrl_r <= {29'h0000_0000, wdata_r[2:0]};
                end
                if (awaddr_r == sbi_pkg::DELAY_OFF)
                begin
                    brake_sequence_delay_param <= DELAY_W'(wdata_r[15:0]);
                end
                if (awaddr_r == sbi_pkg::IRQ_MASK_OFF)
                begin
                    mask_r <= wdata_r[sbi_pkg::EV_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel.
    always_comb
    begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            sbi_pkg::CTRL_OFF: rd_val = ctrl_r;
            sbi_pkg::DELAY_OFF: rd_val = 32'(brake_sequence_delay_param);
            sbi_pkg::STATE_OFF: rd_val = {21'h00_0000, 2'(state_r), warn_r, fault_output, dyn_brake,
                base_on, brake_release, alarm_latched_r, motor_stopped};
            sbi_pkg::IRQ_STAT_OFF: rd_val = 32'(stat_r);
            sbi_pkg::IRQ_MASK_OFF: rd_val = 32'(mask_r);
            default:
            begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sbi_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? sbi_pkg::RESP_OKAY : sbi_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick and shut-off delay counter.
    assign ms_tick = (ms_cnt_r == sbi_pkg::MS_LAST);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_r != sbi_pkg::SQ_BRAKE_WAIT)
        begin
            ms_cnt_r <= 14'h0000;
        end
        else
        begin
            ms_cnt_r <= ms_tick ? 14'h0000 : ms_cnt_r + 14'h0001;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            brake_to_shutoff_delay <= '0;
        end
        else if (state_r != sbi_pkg::SQ_BRAKE_WAIT)
        begin
            brake_to_shutoff_delay <= brake_sequence_delay_param;
        end
        else if (ms_tick && brake_to_shutoff_delay != '0)
        begin
            brake_to_shutoff_delay <= brake_to_shutoff_delay - 1'b1;
        end
    end

    // Alarm is latched until software clears it and the input has gone away.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alarm_latched_r <= 1'b0;
        end
        else if (alarm_in)
        begin
            alarm_latched_r <= 1'b1;
        end
        else if (ctrl_r[sbi_pkg::CTRL_ALARM_CLR_BIT])
        begin
            alarm_latched_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Servo sequence. The controller is trusted to drop servo-on at standstill.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= sbi_pkg::SQ_OFF;
        end
        else if (stop_req)
        begin
            state_r <= sbi_pkg::SQ_STOPPED;
        end
        else
        begin
            case (state_r)
                sbi_pkg::SQ_OFF:
                    if (servo_on_cmd && main_power_ok)
                    begin
                        state_r <= sbi_pkg::SQ_ON;
                    end
                sbi_pkg::SQ_ON:
                    if (!servo_on_cmd || !main_power_ok)
                    begin
                        state_r <= sbi_pkg::SQ_BRAKE_WAIT;
                    end
                sbi_pkg::SQ_BRAKE_WAIT:
                    if (brake_to_shutoff_delay == '0)
                    begin
                        state_r <= sbi_pkg::SQ_OFF;
                    end
                sbi_pkg::SQ_STOPPED:
                    if (!servo_on_cmd)
                    begin
                        state_r <= sbi_pkg::SQ_OFF;
                    end
                default: state_r <= sbi_pkg::SQ_OFF;
            endcase
        end
    end

    // Brake drops on the edge after the stop request, never waiting a cycle for the state.
    always_comb
    begin
        drv_nxt = '0;
        drv_nxt.brake_release = (state_r == sbi_pkg::SQ_ON) && !stop_req && servo_on_cmd
            && main_power_ok;
        drv_nxt.base_on = (state_r == sbi_pkg::SQ_ON || state_r == sbi_pkg::SQ_BRAKE_WAIT)
            && !stop_req;
        drv_nxt.dyn_brake = local_forced_stop_input | fstop_cmd | alarm_latched_r;
        drv_nxt.fault_output = alarm_latched_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            brake_release <= 1'b0;
            base_on <= 1'b0;
            dyn_brake <= 1'b0;
            fault_output <= 1'b0;
        end
        else
        begin
            brake_release <= drv_nxt.brake_release;
            base_on <= drv_nxt.base_on;
            dyn_brake <= drv_nxt.dyn_brake;
            fault_output <= drv_nxt.fault_output;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            warn_r <= '0;
        end
        else
        begin
            warn_r.local_forced_stop_warning <= local_forced_stop_input;
            warn_r.controller_forced_stop_warning <= fstop_cmd;
            warn_r.main_power_off_warning <= ~main_power_ok & control_power_ok & motor_stopped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky events; a new event wins over a write-one clear in the same cycle.
    always_comb
    begin
        ev_set = '0;
        ev_set[sbi_pkg::EV_LOCAL_FSTOP] = local_forced_stop_input & ~warn_r.local_forced_stop_warning;
        ev_set[sbi_pkg::EV_CTRL_FSTOP] = fstop_cmd & ~warn_r.controller_forced_stop_warning;
        ev_set[sbi_pkg::EV_MAIN_OFF] = ~main_off_prev_r & ~main_power_ok & control_power_ok & motor_stopped;
        ev_set[sbi_pkg::EV_ALARM] = alarm_in & ~alarm_latched_r;
        ev_set[sbi_pkg::EV_LOCK_OFF] = lock_prev_r & ~base_on;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stat_r <= '0;
            main_off_prev_r <= 1'b0;
            lock_prev_r <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            main_off_prev_r <= ~main_power_ok & control_power_ok & motor_stopped;
            lock_prev_r <= base_on;
            if (wr_go && wstrb_r[0] && awaddr_r == sbi_pkg::IRQ_STAT_OFF)
            begin
                stat_r <= (stat_r & ~wdata_r[sbi_pkg::EV_W-1:0]) | ev_set;
            end
            else
            begin
                stat_r <= stat_r | ev_set;
            end
            irq <= |(stat_r & mask_r);
        end
    end

endmodule // sbi_sequencer

`default_nettype wire

// ---- testbench/sbi_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbi_checker (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Amplifier status.
    input wire logic local_forced_stop_input,
    input wire logic alarm_in,
    input wire logic main_power_ok,
    input wire logic control_power_ok,
    input wire logic motor_stopped,
    // Drive outputs and write response.
    input wire logic brake_release,
    input wire logic base_on,
    input wire logic dyn_brake,
    input wire logic fault_output,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////
    a_fstop_brake_off: assert property (local_forced_stop_input |=> !brake_release)
        else $error("brake released during local forced stop");
    a_fstop_base_off: assert property (local_forced_stop_input && base_on |=> !base_on && dyn_brake)
        else $error("local forced stop left base on or no dynamic brake");
    // The alarm is latched before it stops the drive, so the drop lands one edge later than a forced stop.
    a_alarm_no_delay: assert property (alarm_in && base_on |=> ##1 (!base_on && !brake_release))
        else $error("alarm did not drop brake and base together");
    a_alarm_latches: assert property (alarm_in |-> ##[1:2] fault_output)
        else $error("alarm not shown on fault output");
    a_power_loss_brake: assert property (!control_power_ok |=> !brake_release && !base_on)
        else $error("brake released without control power");
    a_main_off_quiet: assert property (!main_power_ok && motor_stopped && !alarm_in && !$past(alarm_in)
        && !fault_output |=> !fault_output)
        else $error("main power loss raised fault output");
    a_release_needs_lock: assert property (brake_release |-> base_on)
        else $error("brake released without servo lock");
    a_release_with_lock: assert property ($rose(brake_release) |-> $rose(base_on))
        else $error("brake release and base on did not rise together");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn before taken");
    // The delayed shut-off leaves base on with the brake engaged.
    c_brake_first: cover property ($fell(base_on) && !$past(brake_release));
    c_alarm_run: cover property (alarm_in && base_on);
    c_fstop_run: cover property (local_forced_stop_input && base_on);
endmodule // sbi_checker
`default_nettype wire

// ---- testbench/sbi_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbi_ctl_model (
    // Clock.
    input wire logic aclk,
    // AXI4-Lite master side.
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    // Amplifier state seen by the controller, and the hang flag.
    input wire logic brake_release,
    input wire logic motor_stopped,
    output logic hung
);
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
        s_axi_wstrb = 4'hF;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Each task first lets an edge pass so a back-to-back call never drives a signal twice.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        r = 2'b11;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 64; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hung <= 1'b1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        r = 2'b11;
        d = '0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 64; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hung <= 1'b1;
    endtask
    // The brake delay written by the bench stays short; a real lift axis sets it to the brake lag.
    task automatic servo(input logic on, output logic [1:0] r);
        for (int n = 0; n < 64 && !on && motor_stopped !== 1'b1; n++)
            @(posedge aclk);
        if (!on && motor_stopped !== 1'b1)
            hung <= 1'b1;
        wr(sbi_pkg::CTRL_OFF, {31'h0, on}, r);
        for (int n = 0; n < 64 && on && brake_release !== 1'b1; n++)
            @(posedge aclk);
        if (on && brake_release !== 1'b1)
            hung <= 1'b1;
    endtask
endmodule // sbi_ctl_model
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hung;
    logic local_forced_stop_input = 1'b0;
    logic alarm_in = 1'b0;
    logic main_power_ok = 1'b1;
    logic control_power_ok = 1'b1;
    logic motor_stopped = 1'b1;
    logic brake_release, base_on, dyn_brake, fault_output, irq;
    int bad_count = 0;
    int num_checks = 0;
    int cnt;
    always #50 aclk = ~aclk;
    sbi_sequencer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .local_forced_stop_input, .alarm_in, .main_power_ok, .control_power_ok,
        .motor_stopped, .brake_release, .base_on, .dyn_brake, .fault_output, .irq);
    sbi_ctl_model ctl_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .brake_release, .motor_stopped, .hung);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge hung)
    begin
        bad_count++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        ctl_u.rd(sbi_pkg::DELAY_OFF, d, r);
        chk(d, 32'h0000_0064);
        ctl_u.rd(8'h40, d, r);
        chk({d[29:0], r}, {30'h0, sbi_pkg::RESP_SLVERR});
        ctl_u.wr(sbi_pkg::STATE_OFF, 32'h0000_0000, r);
        chk({30'h0, r}, {30'h0, sbi_pkg::RESP_SLVERR});
        // Two milliseconds keeps the shut-off wait near twenty thousand cycles.
        ctl_u.wr(sbi_pkg::DELAY_OFF, 32'h0000_0002, r);
        ctl_u.wr(sbi_pkg::IRQ_MASK_OFF, 32'h0000_001F, r);
        ctl_u.servo(1'b1, r);
        chk1(brake_release, 1'b1);
        ctl_u.servo(1'b0, r);
        @(posedge aclk);
        chk1(brake_release, 1'b0);
        chk1(base_on, 1'b1);
        cnt = 0;
        while (base_on === 1'b1 && cnt < 30000)
        begin
            @(posedge aclk);
            cnt++;
        end
        chk1(cnt inside {[19990:20010]}, 1'b1);
        ctl_u.rd(sbi_pkg::IRQ_STAT_OFF, d, r);
        chk(d, 32'h0000_0010);
        chk1(irq, 1'b1);
        ctl_u.wr(sbi_pkg::IRQ_STAT_OFF, 32'h0000_001F, r);
        repeat (3) @(posedge aclk);
        chk1(irq, 1'b0);
        // Causes in turn: local stop, controller stop, alarm, control power loss.
        for (int k = 0; k < 4; k++)
        begin
            ctl_u.servo(1'b1, r);
            case (k)
                0: local_forced_stop_input <= 1'b1;
                1: ctl_u.wr(sbi_pkg::CTRL_OFF, 32'h0000_0003, r);
                2: alarm_in <= 1'b1;
                default: control_power_ok <= 1'b0;
            endcase
            repeat (3) @(posedge aclk);
            chk1(brake_release, 1'b0);
            chk1(base_on, 1'b0);
            if (k < 3)
                chk1(dyn_brake, 1'b1);
            chk1(fault_output, k == 2);
            ctl_u.rd(sbi_pkg::STATE_OFF, d, r);
            chk(d & 32'h0000_01C0, k < 2 ? 32'h0000_0040 << k : 32'h0000_0000);
            ctl_u.rd(sbi_pkg::IRQ_STAT_OFF, d, r);
            chk(d, 32'h0000_0010 | (k < 2 ? 32'h0000_0001 << k : k == 2 ? 32'h0000_0008 : 32'h0000_0000));
            local_forced_stop_input <= 1'b0;
            alarm_in <= 1'b0;
            control_power_ok <= 1'b1;
            ctl_u.wr(sbi_pkg::CTRL_OFF, 32'h0000_0004, r);
            ctl_u.wr(sbi_pkg::IRQ_STAT_OFF, 32'h0000_001F, r);
            repeat (3) @(posedge aclk);
            chk1(irq, 1'b0);
            chk1(fault_output, 1'b0);
        end
        // A masked event must latch status yet keep the interrupt line low.
        ctl_u.wr(sbi_pkg::IRQ_MASK_OFF, 32'h0000_0000, r);
        main_power_ok <= 1'b0;
        repeat (3) @(posedge aclk);
        ctl_u.rd(sbi_pkg::STATE_OFF, d, r);
        chk(d & 32'h0000_0120, 32'h0000_0100);
        chk1(fault_output, 1'b0);
        chk1(irq, 1'b0);
        ctl_u.rd(sbi_pkg::IRQ_STAT_OFF, d, r);
        chk(d, 32'h0000_0004);
        tally_and_finish();
    end
endmodule // tb
bind sbi_sequencer sbi_checker chk_u (.aclk, .aresetn, .local_forced_stop_input, .alarm_in, .main_power_ok,
    .control_power_ok, .motor_stopped, .brake_release, .base_on, .dyn_brake, .fault_output, .s_axi_bvalid,
    .s_axi_bready);
`default_nettype wire
